// file: led_pwm_pkg.sv
// Constants for the LED PWM intensity block: register offsets, field layout,
// reset values and PWM timing counts.
// Assumes a 125 MHz system clock and a nominal 32 kHz PWM step rate.
package led_pwm_pkg;
	// Register map, byte offsets on the register port
	localparam logic [7:0] MASTER_OFS = 8'h0E;
	localparam logic [7:0] INTENS_OFS_FIRST = 8'h10;
	localparam logic [7:0] INTENS_OFS_LAST = 8'h17;
	localparam logic [7:0] RSVD_READ = 8'h00;
	// Field layout of the master and seventeenth-output register
	localparam int MASTER_LSB = 4;
	localparam int CODE_W = 4;
	localparam int NUM_INTENS_REGS = 8;
	localparam int NUM_PORTS = 16;
	localparam int NUM_OUTS = 17;
	// Reset values: master zero keeps every output static after reset
	localparam logic [7:0] MASTER_RESET = 8'h00;
	localparam logic [7:0] INTENS_RESET = 8'hFF;
	// Intensity code that means static output
	localparam logic [3:0] STATIC_CODE = 4'hF;
	localparam logic [3:0] MASTER_OFF = 4'h0;
	// PWM period: 15 master timeslots of 16 cycles
	localparam int SLOT_CYCLES = 16;
	localparam int NUM_SLOTS = 15;
	localparam logic [7:0] PERIOD_LAST = 8'(NUM_SLOTS * SLOT_CYCLES - 1);
	// Step rate of the internal oscillator derived from the system clock
	localparam int SYS_FREQ_HZ = 125_000_000;
	localparam int OSC_FREQ_HZ = 32_000;
	localparam int OSC_DIV = SYS_FREQ_HZ / OSC_FREQ_HZ;
	localparam int DIV_W = 12;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
endpackage : led_pwm_pkg

// file: led_pwm_intensity_control.sv
// PWM intensity logic for 16 open-drain ports and a seventeenth output.
// Assumes the register port, global-select and blink bits come from logic on sys_clk.
// Function
// - Master zero: all outputs static, settings ignored
// - Global set: per-output registers ignored
// - Global intensity applies to all outputs
// - Code n: active level lasts (n+1)/16
// - Code 0xF: static level from phase bit
// - Current blink phase bit selects output polarity
// - Seventeenth-output field doubles as global setting
// - Single flag replaces all 16 port settings
// - Master and global fields give 240 steps
// - Period 15 slots of 16, master gates
// - Full scale ignores master gating, static level
// - Phase bit 1 high impedance, 0 low
`timescale 1ns/10ps
`default_nettype none
module led_pwm_intensity_control
	import led_pwm_pkg::*;
#(
	// System clocks per PWM step; a bench may shorten it to reach whole periods
	parameter int STEP_DIV = OSC_DIV
)
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic global_sel,
	input wire logic blink_en,
	input wire logic blink_flip,
	input wire logic [NUM_OUTS-1:0] phase0_bits,
	input wire logic [NUM_OUTS-1:0] phase1_bits,
	output logic [7:0] reg_rdata,
	output logic [NUM_PORTS-1:0] port_out,
	output logic [NUM_PORTS-1:0] port_oe,
	output logic seventeenth_out,
	output logic seventeenth_oe
);

	logic [7:0] master_q, master_d;
	logic [7:0] intens_q [NUM_INTENS_REGS];
	logic [7:0] intens_d [NUM_INTENS_REGS];
	logic [7:0] rdata_q, rdata_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic [7:0] step_q, step_d;
	logic [NUM_OUTS-1:0] low_q, low_d;
	logic [NUM_OUTS-1:0] cur_bits;
	logic [CODE_W-1:0] eff_code [NUM_OUTS];
	logic [3:0] master_f;
	logic [3:0] slot;
	logic [3:0] cyc;
	logic tick;
	logic pwm_on;

	// Divider end count; STEP_DIV must not exceed 2**DIV_W
	localparam logic [DIV_W-1:0] STEP_LAST = DIV_W'(STEP_DIV - 1);

	// Index of a per-output intensity register, valid only inside the window
	function automatic logic [2:0] intens_idx(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - INTENS_OFS_FIRST;
		return rel[2:0];
	endfunction : intens_idx

	function automatic logic in_intens(input logic [7:0] addr);
		return (addr >= INTENS_OFS_FIRST) && (addr <= INTENS_OFS_LAST);
	endfunction : in_intens

	// Drive-low decision for one output
	function automatic logic drive_low(
		input logic on,
		input logic [3:0] code,
		input logic [3:0] m,
		input logic [3:0] s,
		input logic [3:0] c,
		input logic bit_v
	);
		logic active;
		active = 1'b0;
		if (!on || code == STATIC_CODE) begin
			// Static level, no gating, so no glitch at slot edges
			return !bit_v;
		end
		active = (s < m) && (c <= code);
		return bit_v ? !active : active;
	endfunction : drive_low

	assign master_f = master_q[7:MASTER_LSB];
	assign pwm_on = (master_f != MASTER_OFF);
	assign slot = step_q[7:4];
	assign cyc = step_q[3:0];
	assign tick = (div_q == STEP_LAST);
	assign cur_bits = (blink_en && blink_flip) ? phase1_bits : phase0_bits;

	// Effective intensity code of each output
	generate
		for (genvar k = 0; k < NUM_PORTS; k++) begin : g_code
			// One flag switches every port at once; no subset can be global
			assign eff_code[k] = global_sel ? master_q[CODE_W-1:0]
				: intens_q[k/2][(k%2)*CODE_W +: CODE_W];
		end
	endgenerate
	// Own field of the seventeenth output is also the global field
	assign eff_code[NUM_OUTS-1] = master_q[CODE_W-1:0];

	// Register file
	always_comb begin
		master_d = master_q;
		for (int i = 0; i < NUM_INTENS_REGS; i++) begin
			intens_d[i] = intens_q[i];
		end
		if (reg_wr && reg_addr == MASTER_OFS) begin
			master_d = reg_wdata;
		end else if (reg_wr && in_intens(reg_addr)) begin
			intens_d[intens_idx(reg_addr)] = reg_wdata;
		end
		if (reg_addr == MASTER_OFS) begin
			rdata_d = master_q;
		end else if (in_intens(reg_addr)) begin
			rdata_d = intens_q[intens_idx(reg_addr)];
		end else begin
			rdata_d = RSVD_READ;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			master_q <= MASTER_RESET;
			rdata_q <= RSVD_READ;
			for (int i = 0; i < NUM_INTENS_REGS; i++) begin
				intens_q[i] <= INTENS_RESET;
			end
		end else begin
			master_q <= master_d;
			rdata_q <= rdata_d;
			for (int i = 0; i < NUM_INTENS_REGS; i++) begin
				intens_q[i] <= intens_d[i];
			end
		end
	end

	// Oscillator divider and PWM step counter
	always_comb begin
		div_d = div_q;
		step_d = step_q;
		if (!pwm_on) begin
			// Held at period start so PWM restarts cleanly
			div_d = '0;
			step_d = '0;
		end else if (tick) begin
			div_d = '0;
			step_d = (step_q == PERIOD_LAST) ? 8'h00 : step_q + 8'h01;
		end else begin
			div_d = div_q + DIV_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			div_q <= '0;
			step_q <= '0;
		end else begin
			div_q <= div_d;
			step_q <= step_d;
		end
	end

	// Pin drive, registered so outputs never glitch
	always_comb begin
		for (int k = 0; k < NUM_OUTS; k++) begin
			low_d[k] = drive_low(pwm_on, eff_code[k], master_f, slot, cyc, cur_bits[k]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			low_q <= '0;
		end else begin
			low_q <= low_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign port_oe = low_q[NUM_PORTS-1:0];
	assign seventeenth_oe = low_q[NUM_OUTS-1];
	// Open drain: the driven level is always low
	assign port_out = '0;
	assign seventeenth_out = 1'b0;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	static_master_a: assert property (
		!pwm_on |=> port_oe == ~$past(cur_bits[NUM_PORTS-1:0]))
		else $error("master zero but outputs not static");

	counter_stop_a: assert property (
		!pwm_on |=> step_q == 8'h00 && div_q == '0)
		else $error("step counter runs with master zero");

	step_range_a: assert property (
		step_q <= PERIOD_LAST)
		else $error("step counter left the 240-step period");

	step_wrap_a: assert property (
		pwm_on && tick && step_q == PERIOD_LAST ##1 pwm_on |-> step_q == 8'h00)
		else $error("step counter did not wrap after last step");

	global_code_a: assert property (
		global_sel |-> eff_code[5] == master_q[3:0] && eff_code[0] == eff_code[15])
		else $error("global select did not replace per-output code");

	o17_code_a: assert property (
		pwm_on && slot < master_f && cyc <= master_q[3:0] && master_q[3:0] != STATIC_CODE
		|=> seventeenth_oe == !$past(cur_bits[16]))
		else $error("seventeenth output not using its field");

	static_code_a: assert property (
		pwm_on && eff_code[2] == STATIC_CODE |=> port_oe[2] == !$past(cur_bits[2]))
		else $error("code 0xF output not static");

	gate_off_a: assert property (
		pwm_on && slot >= master_f && eff_code[1] != STATIC_CODE
		|=> port_oe[1] == $past(cur_bits[1]))
		else $error("output active outside gated timeslots");

	duty_on_a: assert property (
		pwm_on && slot < master_f && cyc <= eff_code[0] && eff_code[0] != STATIC_CODE
		|=> port_oe[0] == !$past(cur_bits[0]))
		else $error("output not active inside its duty window");

	duty_off_a: assert property (
		pwm_on && slot < master_f && cyc > eff_code[3] && eff_code[3] != STATIC_CODE
		|=> port_oe[3] == $past(cur_bits[3]))
		else $error("output active past its duty window");

	phase_sel_a: assert property (
		blink_en && blink_flip && !pwm_on |=> seventeenth_oe == !$past(phase1_bits[16]))
		else $error("blink phase one bits not used");

	phase0_sel_a: assert property (
		!blink_en && !pwm_on |=> seventeenth_oe == !$past(phase0_bits[16]))
		else $error("blink disabled but phase zero bits not used");

	master_write_a: assert property (
		reg_wr && reg_addr == MASTER_OFS |=> master_q == $past(reg_wdata))
		else $error("master register write lost");

	intens_write_a: assert property (
		reg_wr && in_intens(reg_addr) |=> intens_q[$past(intens_idx(reg_addr))] == $past(reg_wdata))
		else $error("per-output register write lost");

	master_read_a: assert property (
		reg_addr == MASTER_OFS |=> reg_rdata == $past(master_q))
		else $error("master register read back wrong");

	intens_read_a: assert property (
		in_intens(reg_addr) |=> reg_rdata == $past(intens_q[intens_idx(reg_addr)]))
		else $error("per-output register read back wrong");

	div_count_a: assert property (
		pwm_on && !tick |=> div_q == $past(div_q) + DIV_W'(1))
		else $error("step divider did not count");

	step_hold_a: assert property (
		pwm_on && !tick |=> step_q == $past(step_q))
		else $error("step counter moved between ticks");

	step_adv_a: assert property (
		pwm_on && tick && step_q != PERIOD_LAST |=> step_q == $past(step_q) + 8'h01)
		else $error("step counter did not advance on tick");

	// Assumes STEP_DIV above one, so the first tick is still ahead
	step_start_a: assert property (
		!pwm_on ##1 pwm_on |=> step_q == 8'h00 && div_q == DIV_W'(1))
		else $error("PWM did not restart at period start");

	o17_static_a: assert property (
		pwm_on && master_q[3:0] == STATIC_CODE |=> seventeenth_oe == !$past(cur_bits[16]))
		else $error("full-scale seventeenth output not static");

	o17_gate_a: assert property (
		pwm_on && slot >= master_f && master_q[3:0] != STATIC_CODE
		|=> seventeenth_oe == $past(cur_bits[16]))
		else $error("seventeenth output active outside gated timeslots");

	global_duty_a: assert property (
		pwm_on && global_sel && slot < master_f && cyc <= master_q[3:0]
		&& master_q[3:0] != STATIC_CODE |=> port_oe[9] == !$past(cur_bits[9]))
		else $error("global setting did not drive a port");

	global_static_a: assert property (
		pwm_on && global_sel && master_q[3:0] == STATIC_CODE
		|=> port_oe == ~$past(cur_bits[NUM_PORTS-1:0]))
		else $error("full-scale global setting not static on all ports");

	per_port_a: assert property (
		!global_sel |-> eff_code[6] == intens_q[3][3:0] && eff_code[7] == intens_q[3][7:4])
		else $error("per-output code not used with global cleared");

endmodule : led_pwm_intensity_control
`default_nettype wire

// file: led_load.sv
// Load model: LEDs or resistors pulled up on the open-drain pins.
// Assumes oe high means the block sinks the pin low.
`timescale 1ns/10ps
`default_nettype none
module led_load (
	input wire logic [16:0] pin_oe,
	output logic [16:0] pin_lvl
);
	// The pull-up sets the level whenever the block releases the pin
	assign pin_lvl = ~pin_oe;
endmodule : led_load
`default_nettype wire

// file: led_pwm_intensity_control_tb.sv
// Self-checking bench for the LED PWM intensity block.
// Assumes led_pwm_pkg and the pull-up load model led_load.
`timescale 1ns/10ps
`default_nettype none
module led_pwm_intensity_control_tb;
	import led_pwm_pkg::*;
	logic sys_clk = 0, nrst = 0, reg_wr = 0, global_sel = 0, blink_en = 0, blink_flip = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [16:0] ph0 = 17'h0_0000, ph1 = 17'h0_0000, lvl;
	logic [15:0] port_out, port_oe;
	logic s_out, s_oe;
	logic [7:0] sh [9];
	int error_cnt = 0, checks = 0;
	// Short step so whole PWM periods fit the run
	localparam int FAST_DIV = 4;
	always #4 sys_clk = ~sys_clk;
	led_pwm_intensity_control #(.STEP_DIV(FAST_DIV)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .global_sel(global_sel), .blink_en(blink_en),
		.blink_flip(blink_flip), .phase0_bits(ph0), .phase1_bits(ph1), .reg_rdata(reg_rdata),
		.port_out(port_out), .port_oe(port_oe), .seventeenth_out(s_out), .seventeenth_oe(s_oe));
	led_load u_load (.pin_oe({s_oe, port_oe}), .pin_lvl(lvl));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		if (a == MASTER_OFS) sh[8] = d;
		if (a >= INTENS_OFS_FIRST && a <= INTENS_OFS_LAST) sh[a - INTENS_OFS_FIRST] = d;
	endtask : wr
	task automatic pulse_reset(input int len);
		for (int k = 0; k < 9; k++) sh[k] = (k == 8) ? MASTER_RESET : INTENS_RESET;
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (len - 1) @(posedge sys_clk);
		nrst <= 1'b1;
	endtask : pulse_reset
	// Step shown on the pins cnt edges after the edge that wrote a nonzero master
	function automatic logic [7:0] step_at(input int cnt);
		return 8'(((cnt - 1) / FAST_DIV) % (NUM_SLOTS * SLOT_CYCLES));
	endfunction : step_at
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		cmp(32'(reg_rdata), 32'(e));
	endtask : rd
	// Expected pin level: 1 means released, 0 means sunk low
	function automatic logic exp_lvl(input logic [3:0] code, input logic [3:0] m,
		input logic [7:0] step, input logic b);
		logic act;
		if (m == MASTER_OFF || code == STATIC_CODE) return b;
		act = (step[7:4] < m) && (step[3:0] <= code);
		return !(act ^ b);
	endfunction : exp_lvl
	task automatic chk_pins(input logic [7:0] step);
		logic [16:0] bits;
		logic [3:0] code;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		bits = (blink_en && blink_flip) ? ph1 : ph0;
		for (int i = 0; i < 17; i++) begin
			code = (global_sel || i == 16) ? sh[8][3:0] : 4'(sh[i / 2] >> (4 * (i % 2)));
			cmp(32'(lvl[i]), 32'(exp_lvl(code, sh[8][7:4], step, bits[i])));
		end
		cmp(32'({s_out, port_out}), 32'h0000_0000);
	endtask : chk_pins
	initial begin
		int seed, n, r;
		seed = $urandom(47);
		pulse_reset(16);
		rd(MASTER_OFS, MASTER_RESET);
		rd(INTENS_OFS_FIRST, INTENS_RESET);
		rd(8'h0F, RSVD_READ);
		$display("test reset done");
		for (int k = 0; k < 8; k++) wr(INTENS_OFS_FIRST + 8'(k), 8'($urandom));
		wr(MASTER_OFS, {MASTER_OFF, 4'($urandom)});
		wr(8'h0F, 8'h5A);
		for (int k = 0; k < 8; k++) rd(INTENS_OFS_FIRST + 8'(k), sh[k]);
		rd(MASTER_OFS, sh[8]);
		rd(8'h0F, RSVD_READ);
		$display("test registers done");
		// Master zero: every pin follows its phase bit whatever else is set
		for (int k = 0; k < 6; k++) begin
			@(posedge sys_clk);
			ph0 <= 17'($urandom);
			ph1 <= 17'($urandom);
			{global_sel, blink_en, blink_flip} <= (k == 0) ? 3'b011 : 3'($urandom);
			chk_pins(8'h00);
		end
		$display("test static done");
		// Mixed static and PWM ports: a hand-set master, then a random nonzero one
		@(posedge sys_clk);
		global_sel <= 1'b0;
		wr(INTENS_OFS_FIRST, {STATIC_CODE, 4'h0});
		for (int p = 0; p < 2; p++) begin
			// Master zero first, so the step counter starts from a known point
			wr(MASTER_OFS, 8'h07);
			chk_pins(8'h00);
			wr(MASTER_OFS, (p == 0) ? 8'h73 : {4'($urandom % 14 + 1), 4'($urandom)});
			n = 0;
			for (int k = 0; k < 40; k++) begin
				@(posedge sys_clk);
				ph0 <= 17'($urandom);
				ph1 <= 17'($urandom);
				{global_sel, blink_en, blink_flip} <= (k < 8) ? 3'b000 : 3'($urandom);
				r = 8 + $urandom % 48;
				repeat (r) @(posedge sys_clk);
				n += 1 + r;
				chk_pins(step_at(n + 3));
				n += 3;
			end
		end
		$display("test pwm done");
		// Reset in mid-run: registers and pins return to their reset state
		pulse_reset(4);
		rd(MASTER_OFS, MASTER_RESET);
		rd(INTENS_OFS_LAST, INTENS_RESET);
		chk_pins(8'h00);
		$display("test mid-run reset done");
		stop_test;
	end
	initial begin
		repeat (10000) @(posedge sys_clk);
		error_cnt++;
		stop_test;
	end
endmodule : led_pwm_intensity_control_tb
`default_nettype wire
